// File: design/rtucrc_defines.svh
// Constants for the RTU frame and check-code engine
//
// Overview of operation
// - Sender idles the line 3.5 character times; receiver sees that as frame start.
// - Silence derives from line rate and character length; 9600 baud, 10-bit characters give about 3.65ms.
// - Trailing 3.5 character silence closes frame; next character is a station address.
// - First field after frame-start silence is one eight-bit station address.
// - Second field is one function code byte naming the requested action.
// - Function-dependent data field follows, then the frame ends with the check code.
// - Every frame ends with a two-byte, sixteen-bit cyclic check code.
// - Sender computes check over message bytes only and appends it after them.
// - Receiver recomputes the check; on mismatch frame is dropped and no reply sent.
// - Check accumulator presets to all ones at each message start.
// - Each byte is XORed into the accumulator low byte before its shifts.
// - Eight right shifts per byte, XOR with A001 when a one falls out.
// - Check code is appended low byte first, then high byte.
// - Receiver may accumulate over whole frame; zero residual means no error.
// - Character: start, eight data bits LSB first, optional parity, one stop.
// - Station zero is broadcast: act on it but never transmit a reply.
// - No reply to a valid frame carrying an unsupported function code.
`ifndef RTUCRC_DEFINES_SVH
`define RTUCRC_DEFINES_SVH
`define RTUCRC_CLK_HZ        250000000
`define RTUCRC_BAUD          9600
`define RTUCRC_CRC_PRESET    16'hffff
`define RTUCRC_CRC_POLY      16'ha001
`define RTUCRC_CRC_RESIDUE   16'h0000
`define RTUCRC_SIL_HALFCHARS 4'h7
`define RTUCRC_CHAR_BITS     4'ha
`define RTUCRC_LAST_DBIT     3'h7
`define RTUCRC_BROADCAST     8'h00
`define RTUCRC_MIN_FRAME     4'h4
`define RTUCRC_FIFO_DEPTH    8
`endif

// File: design/rtucrc_pkg.sv
// Types shared by the RTU frame and check-code engine
package rtucrc_pkg;
   typedef enum logic [1:0] {RTUCRC_PAR_NONE, RTUCRC_PAR_ODD, RTUCRC_PAR_EVEN} rtucrc_parity_e;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rtucrc_rx_e;
   typedef enum logic [2:0] {TX_IDLE, TX_DATA, TX_CRC_LO, TX_CRC_HI, TX_END} rtucrc_tx_e;
   typedef struct packed {
      logic       last;
      logic [7:0] data;
   } rtucrc_txw_s;
endpackage

// File: design/rtucrc_engine.sv
// RTU frame engine: serial line, silence framing, check code, reply FIFO
`timescale 1ns/1ps
`default_nettype none
`include "rtucrc_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module rtucrc_fifo #(
   parameter int W     = 9,
   parameter int DEPTH = `RTUCRC_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Fill side
   input  wire logic         s_valid,
   output logic              s_ready,
   input  wire logic [W-1:0] s_data,
   // Drain side
   output logic              m_valid,
   input  wire logic         m_ready,
   output logic [W-1:0]      m_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_q [DEPTH];
   logic [AW:0]  wr_q, wr_d, rd_q, rd_d;
   logic         push, pop;

   // Extra pointer bit tells full from empty
   assign s_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
   assign m_valid = wr_q != rd_q;
   assign m_data  = mem_q[rd_q[AW-1:0]];
   assign push    = s_valid & s_ready;
   assign pop     = m_valid & m_ready;

   // Pointer next values
   always_comb begin
      wr_d = push ? wr_q + 1'b1 : wr_q;
      rd_d = pop ? rd_q + 1'b1 : rd_q;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
   end

   // Storage needs no reset
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= s_data;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
module rtucrc_engine #(
   parameter int CLKS_PER_BIT = `RTUCRC_CLK_HZ / `RTUCRC_BAUD
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // Serial line
   input  wire logic                  line_rx,
   output logic                       line_tx,
   output logic                       line_drive,
   // Configuration
   input  wire logic [7:0]            station_addr,
   input  wire rtucrc_pkg::rtucrc_parity_e parity_mode,
   // Received byte stream
   output logic                       rx_valid,
   output logic [7:0]                 rx_data,
   output logic                       rx_first,
   // Frame verdict
   input  wire logic                  func_ok,
   output logic                       frame_good,
   output logic                       frame_drop,
   output logic                       frame_bcast,
   // Reply path
   output logic                       reply_permit,
   input  wire logic                  tx_valid,
   output logic                       tx_ready,
   input  wire rtucrc_pkg::rtucrc_txw_s tx_word,
   output logic                       tx_done
);
   import rtucrc_pkg::*;

   localparam int CW = $clog2(CLKS_PER_BIT + 1);
   localparam logic [CW-1:0] BIT_LAST  = CW'(CLKS_PER_BIT - 1);
   localparam logic [CW-1:0] HALF_LAST = CW'(CLKS_PER_BIT / 2 - 1);

   // One byte folded into the check accumulator
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ `RTUCRC_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // Parity bit for a data byte, zero when parity is off
   function automatic logic par_bit(input rtucrc_parity_e m, input logic [7:0] b);
      return (m == RTUCRC_PAR_ODD) ? ~^b : (m == RTUCRC_PAR_EVEN) ? ^b : 1'b0;
   endfunction

   logic [3:0] char_bits;
   assign char_bits = `RTUCRC_CHAR_BITS + {3'h0, parity_mode != RTUCRC_PAR_NONE};

   ////////////////////////////////////////////////////////////////////////////
   // Line synchroniser, first stage read only by the second
   logic rx_m_q, rx_s_q, rx_p_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_m_q <= 1'b1;
         rx_s_q <= 1'b1;
         rx_p_q <= 1'b1;
      end else begin
         rx_m_q <= line_rx;
         rx_s_q <= rx_m_q;
         rx_p_q <= rx_s_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Silence measurement in half-bit ticks
   logic [CW-1:0] hb_q, hb_d;
   logic [6:0]    sil_q, sil_d;
   logic          silent_q, silent_d, expire;
   logic [6:0]    sil_lim;
   logic          line_edge;
   // 3.5 chars = 7 half-chars; 9600 baud, 10 bits gives about 3.65ms
   assign sil_lim   = 7'(`RTUCRC_SIL_HALFCHARS) * 7'(char_bits);
   assign line_edge = (rx_s_q != rx_p_q) | line_drive;

   always_comb begin
      hb_d     = (hb_q == HALF_LAST) ? '0 : hb_q + 1'b1;
      sil_d    = sil_q;
      silent_d = silent_q;
      expire   = 1'b0;
      if (line_edge) begin
         sil_d    = '0;
         silent_d = 1'b0;
         hb_d     = '0;
      end else if (hb_q == HALF_LAST && !silent_q) begin
         sil_d = sil_q + 1'b1;
         if (sil_d == sil_lim) begin
            silent_d = 1'b1;
            expire   = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hb_q     <= '0;
         sil_q    <= '0;
         silent_q <= 1'b1;
      end else begin
         hb_q     <= hb_d;
         sil_q    <= sil_d;
         silent_q <= silent_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Character receiver, sampled at mid-bit
   rtucrc_rx_e    rx_st_q, rx_st_d;
   logic [CW-1:0] rt_q, rt_d;
   logic [2:0]    rn_q, rn_d;
   logic [7:0]    rsh_q, rsh_d;
   logic          rperr_q, rperr_d, rx_stb, rx_bad;

   always_comb begin
      rx_st_d = rx_st_q;
      rt_d    = (rt_q == '0) ? BIT_LAST : rt_q - 1'b1;
      rn_d    = rn_q;
      rsh_d   = rsh_q;
      rperr_d = rperr_q;
      rx_stb  = 1'b0;
      rx_bad  = 1'b0;
      unique case (rx_st_q)
         RX_IDLE: begin
            rt_d = HALF_LAST;
            if (rx_p_q && !rx_s_q) begin
               rx_st_d = RX_START;
            end
         end
         RX_START: if (rt_q == '0) begin
            rx_st_d = rx_s_q ? RX_IDLE : RX_DATA; // Glitch filter
            rn_d    = '0;
            rperr_d = 1'b0;
         end
         RX_DATA: if (rt_q == '0) begin
            rsh_d = {rx_s_q, rsh_q[7:1]};
            rn_d  = rn_q + 1'b1;
            if (rn_q == `RTUCRC_LAST_DBIT) begin
               rx_st_d = (parity_mode == RTUCRC_PAR_NONE) ? RX_STOP : RX_PAR;
            end
         end
         RX_PAR: if (rt_q == '0) begin
            rperr_d = rx_s_q != par_bit(parity_mode, rsh_q);
            rx_st_d = RX_STOP;
         end
         RX_STOP: if (rt_q == '0) begin
            rx_stb  = 1'b1;
            rx_bad  = rperr_q | ~rx_s_q; // Parity or framing fault
            rx_st_d = RX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_st_q <= RX_IDLE;
         rt_q    <= '0;
         rn_q    <= '0;
         rsh_q   <= '0;
         rperr_q <= 1'b0;
      end else begin
         rx_st_q <= rx_st_d;
         rt_q    <= rt_d;
         rn_q    <= rn_d;
         rsh_q   <= rsh_d;
         rperr_q <= rperr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame assembly, residual check and verdict
   logic [15:0] rcrc_q, rcrc_d;
   logic [3:0]  cnt_q, cnt_d;
   logic        inf_q, inf_d, ferr_q, ferr_d, hit_q, hit_d, bc_q, bc_d;
   logic        rv_q, rv_d, rf_q, rf_d, good_q, good_d, drop_q, drop_d, fb_q, fb_d;
   logic        perm_q, perm_d;
   logic [7:0]  rd_q, rd_d;
   logic        frame_ok, tx_fin;

   // Zero residual over address..check bytes means intact frame
   assign frame_ok = (rcrc_q == `RTUCRC_CRC_RESIDUE) && (cnt_q >= `RTUCRC_MIN_FRAME) && !ferr_q;

   always_comb begin
      {rcrc_d, cnt_d, inf_d, ferr_d, hit_d, bc_d} = {rcrc_q, cnt_q, inf_q, ferr_q, hit_q, bc_q};
      rd_d   = rd_q;
      rv_d   = 1'b0;
      rf_d   = 1'b0;
      good_d = 1'b0;
      drop_d = 1'b0;
      fb_d   = 1'b0;
      perm_d = perm_q & ~tx_fin;
      if (rx_stb) begin
         rv_d = 1'b1;
         rd_d = rsh_q;
         if (!inf_q) begin
            // First character after silence is the station address
            rf_d   = 1'b1;
            inf_d  = 1'b1;
            rcrc_d = crc_byte(`RTUCRC_CRC_PRESET, rsh_q);
            cnt_d  = 4'h1;
            ferr_d = rx_bad;
            hit_d  = (rsh_q == station_addr) || (rsh_q == `RTUCRC_BROADCAST);
            bc_d   = rsh_q == `RTUCRC_BROADCAST;
            perm_d = 1'b0;
         end else begin
            // Function code, data and check bytes all fold in alike
            rcrc_d = crc_byte(rcrc_q, rsh_q);
            cnt_d  = (cnt_q == 4'hf) ? cnt_q : cnt_q + 1'b1;
            ferr_d = ferr_q | rx_bad;
         end
      end
      if (expire && inf_q) begin
         inf_d = 1'b0;
         if (hit_q) begin
            good_d = frame_ok;
            drop_d = !frame_ok;
            fb_d   = frame_ok && bc_q;
            perm_d = frame_ok && !bc_q && func_ok;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rcrc_q <= `RTUCRC_CRC_PRESET;
         cnt_q  <= '0;
         {inf_q, ferr_q, hit_q, bc_q} <= '0;
         {rv_q, rf_q, good_q, drop_q, fb_q, perm_q} <= '0;
         rd_q   <= '0;
      end else begin
         rcrc_q <= rcrc_d;
         cnt_q  <= cnt_d;
         {inf_q, ferr_q, hit_q, bc_q} <= {inf_d, ferr_d, hit_d, bc_d};
         {rv_q, rf_q, good_q, drop_q, fb_q, perm_q} <= {rv_d, rf_d, good_d, drop_d, fb_d, perm_d};
         rd_q   <= rd_d;
      end
   end

   assign rx_valid     = rv_q;
   assign rx_data      = rd_q;
   assign rx_first     = rf_q;
   assign frame_good   = good_q;
   assign frame_drop   = drop_q;
   assign frame_bcast  = fb_q;
   assign reply_permit = perm_q;

   ////////////////////////////////////////////////////////////////////////////
   // Reply FIFO; only open while a reply is permitted
   rtucrc_txw_s f_word;
   logic        f_valid, f_ready, f_sready;

   rtucrc_fifo #(.W($bits(rtucrc_txw_s)), .DEPTH(`RTUCRC_FIFO_DEPTH)) u_fifo (
      .clk     (clk),
      .rst_n   (rst_n),
      .s_valid (tx_valid & perm_q),
      .s_ready (f_sready),
      .s_data  (tx_word),
      .m_valid (f_valid),
      .m_ready (f_ready),
      .m_data  (f_word)
   );
   assign tx_ready = f_sready & perm_q;

   ////////////////////////////////////////////////////////////////////////////
   // Reply sequencer: payload then check code
   rtucrc_tx_e  tx_st_q, tx_st_d;
   logic [15:0] tcrc_q, tcrc_d;
   logic        ld;
   logic [7:0]  ld_byte;
   logic        ser_busy, done_q, done_d;

   always_comb begin
      tx_st_d = tx_st_q;
      tcrc_d  = tcrc_q;
      ld      = 1'b0;
      ld_byte = tcrc_q[7:0];
      f_ready = 1'b0;
      done_d  = 1'b0;
      tx_fin  = 1'b0;
      unique case (tx_st_q)
         TX_IDLE: if (perm_q && f_valid && silent_q) begin
            tx_st_d = TX_DATA;
            tcrc_d  = `RTUCRC_CRC_PRESET;
         end
         // Underrun while sending risks a mid-frame gap; keep FIFO fed
         TX_DATA: if (!ser_busy && f_valid) begin
            ld      = 1'b1;
            ld_byte = f_word.data;
            f_ready = 1'b1;
            tcrc_d  = crc_byte(tcrc_q, f_word.data);
            if (f_word.last) begin
               tx_st_d = TX_CRC_LO;
            end
         end
         TX_CRC_LO: if (!ser_busy) begin
            ld      = 1'b1;
            tx_st_d = TX_CRC_HI;
         end
         TX_CRC_HI: if (!ser_busy) begin
            ld      = 1'b1;
            ld_byte = tcrc_q[15:8];
            tx_st_d = TX_END;
         end
         TX_END: if (!ser_busy) begin
            done_d  = 1'b1;
            tx_fin  = 1'b1;
            tx_st_d = TX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_st_q <= TX_IDLE;
         tcrc_q  <= `RTUCRC_CRC_PRESET;
         done_q  <= 1'b0;
      end else begin
         tx_st_q <= tx_st_d;
         tcrc_q  <= tcrc_d;
         done_q  <= done_d;
      end
   end
   assign tx_done = done_q;

   ////////////////////////////////////////////////////////////////////////////
   // Character transmitter, idle shifts in ones
   logic [10:0]   sh_q, sh_d;
   logic [3:0]    left_q, left_d;
   logic [CW-1:0] st_q, st_d;
   assign ser_busy = left_q != '0;

   always_comb begin
      sh_d   = sh_q;
      left_d = left_q;
      st_d   = st_q;
      if (ld) begin
         // Stop, parity (or extra stop), data LSB first, start
         sh_d = (parity_mode == RTUCRC_PAR_NONE) ? {2'b11, ld_byte, 1'b0}
                : {1'b1, par_bit(parity_mode, ld_byte), ld_byte, 1'b0};
         left_d = char_bits;
         st_d   = BIT_LAST;
      end else if (ser_busy) begin
         st_d = (st_q == '0) ? BIT_LAST : st_q - 1'b1;
         if (st_q == '0) begin
            sh_d   = {1'b1, sh_q[10:1]};
            left_d = left_q - 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sh_q   <= '1;
         left_q <= '0;
         st_q   <= '0;
      end else begin
         sh_q   <= sh_d;
         left_q <= left_d;
         st_q   <= st_d;
      end
   end
   assign line_tx    = sh_q[0];
   assign line_drive = ser_busy;
endmodule
`default_nettype wire

// File: sim/rtucrc_engine_monitor.sv
// Port checker for the RTU frame engine
`timescale 1ns/1ps
`default_nettype none
module rtucrc_engine_monitor #(
   parameter int CLKS_PER_BIT = 16
) (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // Serial line
   input wire logic       line_rx,
   input wire logic       line_tx,
   input wire logic       line_drive,
   // Received stream
   input wire logic       rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic       rx_first,
   // Verdict and reply
   input wire logic       func_ok,
   input wire logic       frame_good,
   input wire logic       frame_drop,
   input wire logic       frame_bcast,
   input wire logic       reply_permit,
   input wire logic       tx_ready,
   input wire logic       tx_done
);
   // Divider may close half a bit early, so allow one bit of slack
   localparam int SIL_MIN = 34 * CLKS_PER_BIT;
   logic [31:0] quiet_q;
   logic [31:0] quiet_d;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////////
   // Idle run length of the incoming line, saturating
   always_comb quiet_d = !line_rx ? '0 : (quiet_q == '1 ? quiet_q : quiet_q + 32'h00000001);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) quiet_q <= '1;
      else quiet_q <= quiet_d;
   end
   ////////////////////////////////////////////////////////////////////////////////
   property p_first_valid; rx_first |-> rx_valid; endproperty
   a_first_valid: assert property (p_first_valid) else $error("first flag without byte");
   property p_data_hold; $changed(rx_data) |-> rx_valid; endproperty
   a_data_hold: assert property (p_data_hold) else $error("byte changed without strobe");
   property p_verdict_excl; frame_good |-> !frame_drop; endproperty
   a_verdict_excl: assert property (p_verdict_excl) else $error("good and drop together");
   property p_drop_silent; frame_drop |-> !reply_permit; endproperty
   a_drop_silent: assert property (p_drop_silent) else $error("reply allowed on dropped frame");
   property p_bcast_good; frame_bcast |-> frame_good && !reply_permit; endproperty
   a_bcast_good: assert property (p_bcast_good) else $error("broadcast handled wrongly");
   property p_permit_cause; $rose(reply_permit) |-> frame_good && !frame_bcast && func_ok; endproperty
   a_permit_cause: assert property (p_permit_cause) else $error("reply allowed without cause");
   property p_ready_permit; tx_ready |-> reply_permit; endproperty
   a_ready_permit: assert property (p_ready_permit) else $error("reply load without permit");
   property p_tx_permit; $rose(line_drive) |-> reply_permit; endproperty
   a_tx_permit: assert property (p_tx_permit) else $error("transmit without permit");
   property p_start_bit; $rose(line_drive) |-> ##1 !line_tx [*7]; endproperty
   a_start_bit: assert property (p_start_bit) else $error("start bit not low");
   property p_close_quiet; frame_good || frame_drop |-> quiet_q >= SIL_MIN; endproperty
   a_close_quiet: assert property (p_close_quiet) else $error("frame closed before silence");
   // Main scenarios reached
   c_good: cover property (frame_good && !frame_bcast);
   c_bcast: cover property (frame_bcast);
   c_drop: cover property (frame_drop);
   c_done: cover property (tx_done);
endmodule
bind rtucrc_engine rtucrc_engine_monitor #(.CLKS_PER_BIT(CLKS_PER_BIT)) u_mon (.clk(clk), .rst_n(rst_n),
   .line_rx(line_rx), .line_tx(line_tx), .line_drive(line_drive), .rx_valid(rx_valid), .rx_data(rx_data),
   .rx_first(rx_first), .func_ok(func_ok), .frame_good(frame_good), .frame_drop(frame_drop),
   .frame_bcast(frame_bcast), .reply_permit(reply_permit), .tx_ready(tx_ready), .tx_done(tx_done));
`default_nettype wire

// File: sim/rtucrc_master_model.sv
// Bus master model: sends requests, collects reply characters
`timescale 1ns/1ps
`default_nettype none
module rtucrc_master_model #(
   parameter int CPB = 16
) (
   // Clock
   input  wire logic                       clk,
   // Serial line
   output var logic                        line_rx,
   input  wire logic                       line_tx,
   input  wire logic                       line_drive,
   // Character format
   input  wire rtucrc_pkg::rtucrc_parity_e parity_mode
);
   import rtucrc_pkg::*;
   logic [7:0] rxq [$];
   logic [7:0] rx_b;
   logic       line_bus;
   ////////////////////////////////////////////////////////////////////////////////
   // Reference check code
   function automatic logic [15:0] crc16(input logic [7:0] m [$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (m[i]) begin
         c = c ^ {8'h00, m[i]};
         for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
      return c;
   endfunction
   // One character, entered and left on a falling edge
   task automatic send_char(input logic [7:0] b, input bit bad_par);
      logic [10:0] f;
      int nb;
      nb = (parity_mode == RTUCRC_PAR_NONE) ? 10 : 11;
      f = (nb == 10) ? {2'b11, b, 1'b0} : {1'b1, ^b ^ (parity_mode == RTUCRC_PAR_ODD) ^ bad_par, b, 1'b0};
      for (int i = 0; i < nb; i++) begin
         line_rx = f[i];
         repeat (CPB) @(negedge clk);
      end
   endtask
   // Whole request; idle line stays high, as biased
   task automatic send_frame(input logic [7:0] m [$], input bit bad_crc, input bit bad_par);
      logic [15:0] c;
      c = crc16(m);
      repeat (40 * CPB) @(negedge clk);
      foreach (m[i]) send_char(m[i], bad_par && i == 0);
      send_char(c[7:0] ^ {7'h00, bad_crc}, 1'b0);
      send_char(c[15:8], 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Reply capture at mid-bit
   initial line_rx = 1'b1;
   // Released driver leaves the line at its idle bias
   assign line_bus = line_drive ? line_tx : 1'b1;
   always begin
      @(negedge line_bus);
      repeat (CPB / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (CPB) @(posedge clk);
         rx_b[i] = line_bus;
      end
      rxq.push_back(rx_b);
      repeat ((parity_mode == RTUCRC_PAR_NONE) ? CPB : 2 * CPB) @(posedge clk);
   end
endmodule
`default_nettype wire

// File: sim/rtucrc_engine_tb.sv
// Self-checking bench for the RTU frame engine
`timescale 1ns/1ps
`default_nettype none
module rtucrc_engine_tb;
   import rtucrc_pkg::*;
   localparam int CPB = 16;
   // Row: station, message, length, function ok, bad code, {good,drop,bcast,permit}
   typedef struct packed {
      logic [7:0]  st;
      logic [31:0] msg;
      logic [2:0]  n;
      logic        fok;
      logic        bad;
      logic [3:0]  exp;
   } rtucrc_row_s;
   logic           clk, rst_n, line_rx, line_tx, line_drive, rx_valid, rx_first, func_ok;
   logic           frame_good, frame_drop, frame_bcast, reply_permit, tx_valid, tx_ready, tx_done;
   logic [7:0]     station_addr, rx_data;
   rtucrc_parity_e parity_mode;
   rtucrc_txw_s    tx_word;
   logic [7:0]     m [$];
   logic [8:0]     got [$];
   logic [3:0]     v;
   logic [15:0]    c;
   int             fail_count, n_compared, stalls, k;
   rtucrc_row_s rows [7] = '{
      '{8'h11, 32'h11030001, 3'h4, 1'b1, 1'b0, 4'b1001},
      '{8'h11, 32'h11030001, 3'h4, 1'b1, 1'b1, 4'b0100},
      '{8'h11, 32'h00060005, 3'h4, 1'b1, 1'b0, 4'b1010},
      '{8'h11, 32'h22030001, 3'h4, 1'b1, 1'b0, 4'b0000},
      '{8'h11, 32'h11420000, 3'h2, 1'b0, 1'b0, 4'b1000},
      '{8'h11, 32'h11000000, 3'h1, 1'b1, 1'b0, 4'b0100},
      '{8'h02, 32'h02070000, 3'h2, 1'b0, 1'b0, 4'b1000}};
   ////////////////////////////////////////////////////////////////////////////////
   rtucrc_engine #(.CLKS_PER_BIT(CPB)) dut (.clk(clk), .rst_n(rst_n), .line_rx(line_rx), .line_tx(line_tx),
      .line_drive(line_drive), .station_addr(station_addr), .parity_mode(parity_mode), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_first(rx_first), .func_ok(func_ok), .frame_good(frame_good),
      .frame_drop(frame_drop), .frame_bcast(frame_bcast), .reply_permit(reply_permit), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_word(tx_word), .tx_done(tx_done));
   rtucrc_master_model #(.CPB(CPB)) u_master (.clk(clk), .line_rx(line_rx), .line_tx(line_tx), .line_drive(line_drive),
      .parity_mode(parity_mode));
   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Received bytes with their first-byte flag
   always @(negedge clk) if (rx_valid === 1'b1) got.push_back({rx_first, rx_data});
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Send one request and catch the verdict; silent frames give zero
   task automatic run_frame(input bit bad_crc, input bit bad_par);
      got.delete();
      u_master.send_frame(m, bad_crc, bad_par);
      v = 4'h0;
      for (int i = 0; i < 1500; i++) begin
         @(negedge clk);
         if ((frame_good | frame_drop) === 1'b1) begin
            v = {frame_good, frame_drop, frame_bcast, reply_permit};
            break;
         end
      end
   endtask
   task automatic final_report();
      $display("Compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Hang guard, well past the expected run length
   initial begin
      #(60000 * 4);
      fail_count++;
      $display("[FAIL] watchdog expected finish seen timeout");
      final_report();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      station_addr = 8'h11;
      parity_mode = RTUCRC_PAR_NONE;
      func_ok = 1'b0;
      tx_valid = 1'b0;
      tx_word = '0;
      repeat (4) @(negedge clk);
      check("reset outputs", {line_tx, line_drive, reply_permit, frame_good, rx_data}, 12'h800);
      rst_n = 1'b1;
      check("model code", u_master.crc16('{8'h02, 8'h07}), 16'h1241);
      // Table of plain frames
      foreach (rows[r]) begin
         m.delete();
         for (int i = 0; i < rows[r].n; i++) m.push_back(rows[r].msg[31 - 8 * i -: 8]);
         station_addr = rows[r].st;
         func_ok = rows[r].fok;
         run_frame(rows[r].bad, 1'b0);
         check("verdict", v, rows[r].exp);
         check("first byte", got[0], {1'b1, m[0]});
         check("byte count", got.size(), rows[r].n + 2);
      end
      // Both parity senses, then a flipped parity bit
      station_addr = 8'h11;
      m = '{8'h11, 8'h03, 8'h00, 8'h01};
      for (int p = 1; p < 4; p++) begin
         parity_mode = (p == 1) ? RTUCRC_PAR_ODD : RTUCRC_PAR_EVEN;
         run_frame(1'b0, p == 3);
         check("parity", v, (p == 3) ? 4'b0100 : 4'b1000);
      end
      parity_mode = RTUCRC_PAR_NONE;
      // Reply longer than the buffer, so loading must stall
      func_ok = 1'b1;
      run_frame(1'b0, 1'b0);
      check("permit", v, 4'b1001);
      m.delete();
      for (int i = 0; i < 10; i++) m.push_back(8'(8'h30 + i));
      u_master.rxq.delete();
      stalls = 0;
      foreach (m[i]) begin
         tx_word = '{last: i == 9, data: m[i]};
         tx_valid = 1'b1;
         while (tx_ready !== 1'b1 && stalls < 20000) begin
            @(negedge clk);
            stalls++;
         end
         @(negedge clk);
      end
      tx_valid = 1'b0;
      k = 0;
      while (tx_done !== 1'b1 && k < 5000) begin
         @(negedge clk);
         k++;
      end
      check("reply done", tx_done, 1'b1);
      repeat (2 * CPB) @(negedge clk);
      c = u_master.crc16(m);
      m.push_back(c[7:0]);
      m.push_back(c[15:8]);
      check("reply length", u_master.rxq.size(), 12);
      foreach (m[i]) check("reply byte", u_master.rxq[i], m[i]);
      check("buffer refused", stalls != 0, 1'b1);
      check("permit after reply", reply_permit, 1'b0);
      // Reset in mid-reply, then a fresh frame must be taken
      m = '{8'h11, 8'h03, 8'h00, 8'h01};
      run_frame(1'b0, 1'b0);
      check("permit again", v, 4'b1001);
      tx_word = '{last: 1'b1, data: 8'h5a};
      tx_valid = 1'b1;
      @(negedge clk);
      tx_valid = 1'b0;
      repeat (40) @(negedge clk);
      check("sending", line_drive, 1'b1);
      rst_n = 1'b0;
      repeat (4) @(negedge clk);
      check("mid reset", {line_tx, line_drive, reply_permit, tx_ready}, 4'h8);
      rst_n = 1'b1;
      run_frame(1'b0, 1'b0);
      check("after reset", v, 4'b1001);
      final_report();
   end
endmodule
`default_nettype wire
